// ==== rtl/dcm_clock_mgmt.sv ====
`timescale 1ns/1ns
`include "dcm_defines.svh"

module dcm_clock_mgmt (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // strap pins
    input  wire logic                  div_sel_lo,
    input  wire logic                  div_sel_hi,
    input  wire logic                  mult_sel,
    input  wire logic                  cpu_clk_sel,
    // master clock sources
    input  wire logic                  ext_master_clk_in,
    input  wire logic                  crystal_in,
    output logic                       master_clk_echo,
    // serial audio port clocks
    input  wire logic                  ext_bit_clk_in,
    output logic                       in_bit_clk_out,
    output logic                       out_bit_clk_out,
    input  wire logic                  frame_clk_in,
    output logic                       frame_clk_out,
    output logic                       frame_clk_oe,
    output logic                       frame_clk,
    output logic                       in_sample_stb,
    output logic                       out_shift_stb,
    // core clock configuration
    output dcm_pkg::dcm_core_cfg_t     core_cfg,
    output logic                       cpu_tick,
    output logic [3:0]                 i2c_n,
    output logic [3:0]                 i2c_m,
    // avalon-mm slave
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest
);

    // ======================================================
    // strap capture
    dcm_pkg::dcm_strap_t strap;

    // pins are only legal to move under reset, so keep
    // sampling while held and freeze at release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap <= '{mult_sel, {div_sel_hi, div_sel_lo},
                       cpu_clk_sel};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            core_cfg <= '{`DCM_DSP_MULT, `DCM_DIV1, `DCM_DIV1,
                          1'b0};
        end else begin
            core_cfg.dsp_mult <= `DCM_DSP_MULT;
            core_cfg.cpu_div  <= strap.cpu_clk_sel ?
                                 `DCM_DIV1 : `DCM_CPU_DIV;
            core_cfg.reserved_code <= strap.mult_sel ||
                (strap.div_sel == `DCM_CODE_RSV);
            if (strap.mult_sel) begin
                core_cfg.dsp_div <= `DCM_DIV1;
            end else begin
                unique case (strap.div_sel)
                    `DCM_CODE_DIV1: core_cfg.dsp_div <= `DCM_DIV1;
                    `DCM_CODE_DIV2: core_cfg.dsp_div <= `DCM_DIV2;
                    `DCM_CODE_DIV4: core_cfg.dsp_div <= `DCM_DIV4;
                    default:        core_cfg.dsp_div <= `DCM_DIV1;
                endcase
            end
        end
    end

    // ======================================================
    // cpu clock enable, mclk stands in for processing clock
    logic [1:0] cpu_cnt;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_cnt  <= 2'h0;
            cpu_tick <= 1'b0;
        end else begin
            cpu_cnt  <= cpu_cnt + 2'h1;
            cpu_tick <= strap.cpu_clk_sel ||
                        (cpu_cnt == `DCM_CPU_LAST);
        end
    end

    // ======================================================
    // register file
    dcm_pkg::dcm_sap_mode_t  sap_mode;
    dcm_pkg::dcm_bus_state_t bus_state;
    logic [`DCM_BDIV_W-1:0]  bdiv [2];
    logic [`DCM_FDIV_W-1:0]  fdiv;
    logic                    wr_ok;

    assign avs_waitrequest = (avs_read || avs_write) &&
                             (bus_state == dcm_pkg::DCM_BUS_IDLE);
    assign wr_ok = avs_write && (bus_state == dcm_pkg::DCM_BUS_ACK);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_state <= dcm_pkg::DCM_BUS_IDLE;
        end else begin
            unique case (bus_state)
                dcm_pkg::DCM_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state <= dcm_pkg::DCM_BUS_ACK;
                    end
                end
                dcm_pkg::DCM_BUS_ACK: begin
                    bus_state <= dcm_pkg::DCM_BUS_IDLE;
                end
            endcase
        end
    end

    // writes retune the dividers live; nothing else is reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sap_mode <= dcm_pkg::DCM_SLAVE;
            bdiv[0]  <= `DCM_RST_BDIV;
            bdiv[1]  <= `DCM_RST_BDIV;
            fdiv     <= `DCM_RST_FDIV;
            i2c_n    <= `DCM_RST_I2C_N;
            i2c_m    <= `DCM_RST_I2C_M;
        end else if (wr_ok) begin
            unique case (avs_address)
                `DCM_ADR_MODE: sap_mode <=
                    dcm_pkg::dcm_sap_mode_t'(avs_writedata[0]);
                `DCM_ADR_BDIV: begin
                    bdiv[0] <= avs_writedata[`DCM_BDIV_W-1:0];
                    bdiv[1] <= avs_writedata[2*`DCM_BDIV_W-1:
                                             `DCM_BDIV_W];
                end
                `DCM_ADR_FDIV: fdiv <= avs_writedata[`DCM_FDIV_W-1:0];
                `DCM_ADR_I2C: begin
                    i2c_n <= avs_writedata[`DCM_I2C_N_LSB+:4];
                    i2c_m <= avs_writedata[`DCM_I2C_M_LSB+:4];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_readdata <= `DCM_ZERO32;
        end else if (avs_read &&
                     bus_state == dcm_pkg::DCM_BUS_IDLE) begin
            unique case (avs_address)
                `DCM_ADR_MODE: avs_readdata <= {31'h0, sap_mode};
                `DCM_ADR_BDIV: avs_readdata <= {16'h0, bdiv[1],
                                                bdiv[0]};
                `DCM_ADR_FDIV: avs_readdata <= {22'h0, fdiv};
                `DCM_ADR_I2C:  avs_readdata <= {24'h0, i2c_m, i2c_n};
                `DCM_ADR_STAT: avs_readdata <= {19'h0, core_cfg,
                                                1'b0, sap_mode};
                default:       avs_readdata <= `DCM_ZERO32;
            endcase
        end
    end

    // ======================================================
    // clock sources
    logic msrc_q;
    logic msrc_qq;
    logic ext_q;
    logic ext_qq;
    logic m_rise;
    logic e_rise;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            msrc_q  <= 1'b0;
            msrc_qq <= 1'b0;
            ext_q   <= 1'b0;
            ext_qq  <= 1'b0;
            master_clk_echo <= 1'b0;
        end else begin
            msrc_q  <= crystal_in | ext_master_clk_in;
            msrc_qq <= msrc_q;
            ext_q   <= ext_bit_clk_in;
            ext_qq  <= ext_q;
            master_clk_echo <= msrc_q;
        end
    end

    assign m_rise = msrc_q & ~msrc_qq;
    assign e_rise = ext_q & ~ext_qq;

    // ======================================================
    // bit clock dividers: 0 feeds the input port, 1 the output
    logic [1:0] bclk;
    logic [1:0] bclk_q;
    logic       is_master;

    assign is_master = (sap_mode == dcm_pkg::DCM_MASTER);

    generate
        for (genvar i = 0; i < 2; i++) begin : g_bclk
            logic [`DCM_BDIV_W-1:0] cnt;
            logic                   src_rise;
            logic                   src_lvl;

            assign src_rise = is_master ? m_rise : e_rise;
            assign src_lvl  = is_master ? msrc_q : ext_q;

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    cnt     <= '0;
                    bclk[i] <= 1'b0;
                end else if (bdiv[i] <= `DCM_RST_BDIV) begin
                    cnt     <= '0;
                    bclk[i] <= src_lvl;
                end else begin
                    if (src_rise) begin
                        cnt <= (cnt >= bdiv[i] - `DCM_RST_BDIV) ?
                               '0 : cnt + `DCM_RST_BDIV;
                    end
                    bclk[i] <= (cnt < (bdiv[i] >> 1));
                end
            end
        end
    endgenerate

    assign in_bit_clk_out  = bclk[0];
    assign out_bit_clk_out = bclk[1];

    // data is taken on the rising input bit clock and moved
    // on the falling output bit clock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bclk_q        <= 2'h0;
            in_sample_stb <= 1'b0;
            out_shift_stb <= 1'b0;
        end else begin
            bclk_q        <= bclk;
            in_sample_stb <= bclk[0] & ~bclk_q[0];
            out_shift_stb <= ~bclk[1] & bclk_q[1];
        end
    end

    // ======================================================
    // frame clock
    logic [`DCM_FDIV_W-1:0] fcnt;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fcnt          <= '0;
            frame_clk_out <= 1'b0;
            frame_clk     <= 1'b0;
        end else begin
            if (is_master && out_shift_stb) begin
                fcnt <= (fcnt >= fdiv - 10'h001) ?
                        '0 : fcnt + 10'h001;
            end
            frame_clk_out <= is_master && (fcnt < (fdiv >> 1));
            frame_clk     <= is_master ? frame_clk_out
                                       : frame_clk_in;
        end
    end

    assign frame_clk_oe = is_master;

    // ======================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_mode;
        avs_write && !avs_waitrequest &&
        avs_address == `DCM_ADR_MODE;
    endsequence
    property p_dsp_div;
        $past(rst_n) |-> core_cfg.dsp_div ==
            ((strap.mult_sel || strap.div_sel == `DCM_CODE_RSV) ?
             `DCM_DIV1 :
             (strap.div_sel == `DCM_CODE_DIV2) ? `DCM_DIV2 :
             (strap.div_sel == `DCM_CODE_DIV4) ? `DCM_DIV4 : `DCM_DIV1);
    endproperty
    a_dsp_div: assert property (p_dsp_div)
        else $error("processing divider wrong for strap");
    property p_cpu_quarter;
        !strap.cpu_clk_sel && cpu_tick |=> !cpu_tick [*3] ##1 cpu_tick;
    endproperty
    a_cpu_quarter: assert property (p_cpu_quarter)
        else $error("cpu tick not one in four");
    property p_strap_hold;
        $past(rst_n) |-> $stable(strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap changed after reset");
    property p_mode_write;
        s_wr_mode |=> sap_mode == $past(avs_writedata[0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode write not taken");
    property p_keep_regs;
        avs_write && !avs_waitrequest &&
        avs_address == `DCM_ADR_BDIV |=> $stable(i2c_m) &&
        $stable(sap_mode) && $stable(fdiv);
    endproperty
    a_keep_regs: assert property (p_keep_regs)
        else $error("divider change disturbed other registers");
    property p_reset_defaults;
        $rose(rst_n) |-> sap_mode == dcm_pkg::DCM_SLAVE &&
        i2c_n == `DCM_RST_I2C_N && i2c_m == `DCM_RST_I2C_M &&
        !frame_clk_oe;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("reset defaults wrong");
    property p_slave_follow;
        !is_master && bdiv[0] == `DCM_RST_BDIV && $stable(bdiv[0])
        |-> in_bit_clk_out == $past(ext_q);
    endproperty
    a_slave_follow: assert property (p_slave_follow)
        else $error("input bit clock not following external");
    // the frame output is registered, so it may stand one cycle
    // after a switch back to slave
    property p_frame_dir;
        frame_clk_oe == is_master &&
        ($past(is_master) || !frame_clk_out);
    endproperty
    a_frame_dir: assert property (p_frame_dir)
        else $error("frame clock direction wrong");
    property p_in_sample;
        $rose(in_bit_clk_out) |=> in_sample_stb ##1 !in_sample_stb;
    endproperty
    a_in_sample: assert property (p_in_sample)
        else $error("input sample strobe missing");
    property p_mult;
        $past(rst_n) |-> core_cfg.dsp_mult == `DCM_DSP_MULT;
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiplier not eleven");
endmodule

// ==== shared/dcm_defines.svh ====
// Function
// - processing clock is master x11 over 1/2/4
// - cpu clock is processing clock or quarter
// - rate changes keep operating and registers
// - master mode drives both bit clocks, frame
// - slave mode: frame input, bit clocks external
// - bit clock outputs time serial data
// - host selects mode and master frequencies
// - reset defaults: follow, slave, x11, N0, M8
`ifndef DCM_DEFINES_SVH
`define DCM_DEFINES_SVH

// ==========================================================
// register byte addresses
`define DCM_ADR_MODE     5'h00
`define DCM_ADR_BDIV     5'h04
`define DCM_ADR_FDIV     5'h08
`define DCM_ADR_I2C      5'h0c
`define DCM_ADR_STAT     5'h10

// ==========================================================
// fields and reset values
`define DCM_BDIV_W       8
`define DCM_FDIV_W       10
`define DCM_RST_BDIV     8'h01
`define DCM_RST_FDIV     10'h040
`define DCM_RST_I2C_N    4'h0
`define DCM_RST_I2C_M    4'h8
`define DCM_I2C_N_LSB    0
`define DCM_I2C_M_LSB    4
`define DCM_ZERO32       32'h0000_0000

// ==========================================================
// clock ratios
`define DCM_DSP_MULT     4'hb
`define DCM_DIV1         3'h1
`define DCM_DIV2         3'h2
`define DCM_DIV4         3'h4
`define DCM_CPU_DIV      3'h4
`define DCM_CPU_LAST     2'h3
`define DCM_CODE_DIV1    2'h0
`define DCM_CODE_DIV2    2'h1
`define DCM_CODE_DIV4    2'h2
`define DCM_CODE_RSV     2'h3

`endif

// ==== shared/dcm_pkg.sv ====
package dcm_pkg;

    // strap pins caught at reset
    typedef struct packed {
        logic       mult_sel;
        logic [1:0] div_sel;
        logic       cpu_clk_sel;
    } dcm_strap_t;

    // ratios handed to the processing and cpu clock tree
    typedef struct packed {
        logic [3:0] dsp_mult;
        logic [2:0] dsp_div;
        logic [2:0] cpu_div;
        logic       reserved_code;
    } dcm_core_cfg_t;

    typedef enum logic {
        DCM_SLAVE  = 1'b0,
        DCM_MASTER = 1'b1
    } dcm_sap_mode_t;

    typedef enum logic {
        DCM_BUS_IDLE = 1'b0,
        DCM_BUS_ACK  = 1'b1
    } dcm_bus_state_t;

endpackage

// ==== tb/dcm_far_side.sv ====
`timescale 1ns/1ns
module dcm_far_side (
    // frame pin, device side
    input  wire logic frame_clk_oe,
    input  wire logic frame_clk_out,
    // clock sources
    output logic      ext_master_clk_in,
    output logic      crystal_in,
    output logic      ext_bit_clk_in,
    output logic      frame_clk_in
);
    logic       lr = 1'b0;
    logic [5:0] bits = 6'h00;

    // ==========================================
    // free-running master and bit clocks, crystal tied low; only master clock edges kept off the mclk grid
    assign crystal_in = 1'b0;
    initial begin
        ext_master_clk_in = 1'b0;
        #1;
        forever #22 ext_master_clk_in = ~ext_master_clk_in;
    end
    initial begin
        ext_bit_clk_in = 1'b0;
        #3;
        forever #41 ext_bit_clk_in = ~ext_bit_clk_in;
    end
    always @(negedge ext_bit_clk_in) begin
        bits <= bits + 6'h01;
        if (bits == 6'h3f) begin
            lr <= ~lr;
        end
    end
    // the pin shows the device's frame clock while it drives
    assign frame_clk_in = frame_clk_oe ? frame_clk_out : lr;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "dcm_defines.svh"
module testbench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        div_sel_lo = 1'b0;
    logic        div_sel_hi = 1'b0;
    logic        mult_sel = 1'b0;
    logic        cpu_clk_sel = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic        ext_master_clk_in, crystal_in, ext_bit_clk_in;
    logic        frame_clk_in, master_clk_echo, in_bit_clk_out;
    logic        out_bit_clk_out, frame_clk_out, frame_clk_oe;
    logic        frame_clk, in_sample_stb, out_shift_stb, cpu_tick;
    logic [3:0]  i2c_n, i2c_m;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  bq = 2'h0;
    logic [1:0]  mq = 2'h0;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    dcm_pkg::dcm_core_cfg_t core_cfg;

    dcm_clock_mgmt u_dcm_clock_mgmt (
        .mclk, .rst_n, .div_sel_lo, .div_sel_hi, .mult_sel, .cpu_clk_sel,
        .ext_master_clk_in, .crystal_in, .master_clk_echo,
        .ext_bit_clk_in, .in_bit_clk_out, .out_bit_clk_out,
        .frame_clk_in, .frame_clk_out, .frame_clk_oe, .frame_clk,
        .in_sample_stb, .out_shift_stb, .core_cfg, .cpu_tick,
        .i2c_n, .i2c_m, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest
    );
    dcm_far_side u_dcm_far_side (
        .frame_clk_oe, .frame_clk_out, .ext_master_clk_in,
        .crystal_in, .ext_bit_clk_in, .frame_clk_in
    );

    // ==========================================
    // clock, pin history, hang guard
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        bq <= {bq[0], ext_bit_clk_in};
        mq <= {mq[0], ext_master_clk_in | crystal_in};
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            conclude();
        end
    end

    // ==========================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] s, input logic c);
        @(posedge mclk);
        rst_n <= 1'b0;
        {mult_sel, div_sel_hi, div_sel_lo} <= s;
        cpu_clk_sel <= c;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    // the request stands until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [4:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(nm, q, e);
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? in_bit_clk_out :
               (s == 1) ? out_bit_clk_out : frame_clk;
    endfunction

    // cycles between two rising edges of the picked clock
    task automatic meas(input int s, output int per);
        int   n;
        logic pv;
        logic cu;
        n = 0;
        per = 0;
        @(negedge mclk);
        pv = pick(s);
        while (n < 2) begin
            @(negedge mclk);
            cu = pick(s);
            if (n == 1) per++;
            if (cu && !pv) n++;
            pv = cu;
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_defaults;
        rd("mode", `DCM_ADR_MODE, 32'h0000_0000);
        rd("bdiv", `DCM_ADR_BDIV, 32'h0000_0101);
        rd("fdiv", `DCM_ADR_FDIV, 32'h0000_0040);
        rd("i2c", `DCM_ADR_I2C, 32'h0000_0080);
        wr(5'h14, 32'h0000_ffff);
        rd("unmapped", 5'h14, 32'h0000_0000);
        check("frame oe", frame_clk_oe, 32'h0000_0000);
    endtask

    task automatic t_slave;
        int         e_clk;
        int         e_stb;
        int         p;
        logic [1:0] hi;
        logic [1:0] ho;
        e_clk = 0;
        e_stb = 0;
        @(negedge mclk);
        hi[1] = in_bit_clk_out;
        ho[1] = out_bit_clk_out;
        @(negedge mclk);
        hi[0] = in_bit_clk_out;
        ho[0] = out_bit_clk_out;
        repeat (400) begin
            @(negedge mclk);
            e_clk += (in_bit_clk_out !== bq[1]) + (out_bit_clk_out !== bq[1])
                   + (master_clk_echo !== mq[1]);
            e_stb += (in_sample_stb !== (hi[0] & ~hi[1]))
                   + (out_shift_stb !== (~ho[0] & ho[1]));
            hi = {hi[0], in_bit_clk_out};
            ho = {ho[0], out_bit_clk_out};
        end
        check("follow", e_clk, 32'h0000_0000);
        check("strobes", e_stb, 32'h0000_0000);
        meas(2, p);
        check("slave frame", p >= 2623 && p <= 2625, 32'h0000_0001);
    endtask

    task automatic t_master;
        int p;
        wr(`DCM_ADR_MODE, 32'h0000_0001);
        @(negedge mclk);
        check("frame oe", frame_clk_oe, 32'h0000_0001);
        meas(0, p);
        check("in bit div1", p, 32'h0000_000b);
        wr(`DCM_ADR_BDIV, 32'h0000_0402);
        wr(`DCM_ADR_FDIV, 32'h0000_0004);
        repeat (400) @(posedge mclk);
        meas(0, p);
        check("in bit div2", p, 32'h0000_0016);
        meas(1, p);
        check("out bit div4", p, 32'h0000_002c);
        meas(2, p);
        check("frame", p, 32'h0000_00b0);
        rd("mode kept", `DCM_ADR_MODE, 32'h0000_0001);
        rd("i2c kept", `DCM_ADR_I2C, 32'h0000_0080);
        wr(`DCM_ADR_I2C, 32'h0000_0035);
        @(negedge mclk);
        check("i2c_n", i2c_n, 32'h0000_0005);
        check("i2c_m", i2c_m, 32'h0000_0003);
        rd("stat", `DCM_ADR_STAT, {19'h0_0000, 4'hb, 3'h4, 3'h4, 3'h1});
        wr(`DCM_ADR_MODE, 32'h0000_0000);
        @(negedge mclk);
        check("frame oe off", frame_clk_oe, 32'h0000_0000);
        @(negedge mclk);
        check("frame out off", frame_clk_out, 32'h0000_0000);
    endtask

    task automatic t_straps;
        logic [2:0] sv [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
        logic [2:0] ed [5] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h1};
        logic [4:0] rsv = 5'h18;
        logic [10:0] e;
        int n;
        for (int i = 0; i < 5; i++) begin
            do_reset(sv[i], i[0]);
            e = {4'hb, ed[i], i[0] ? 3'h1 : 3'h4, rsv[i]};
            @(negedge mclk);
            check("core cfg", core_cfg, e);
            check("i2c_m reset", i2c_m, 32'h0000_0008);
            n = 0;
            repeat (8) begin
                @(negedge mclk);
                n += cpu_tick;
            end
            check("cpu ticks", n, i[0] ? 8 : 2);
            @(posedge mclk);
            {mult_sel, div_sel_hi, div_sel_lo} <= ~sv[i];
            cpu_clk_sel <= ~i[0];
            repeat (4) @(negedge mclk);
            check("straps held", core_cfg, e);
        end
    endtask

    initial begin
        // divide by four and quarter cpu clock keep both clocks in range
        do_reset(3'h2, 1'b0);
        t_defaults();
        t_slave();
        t_master();
        t_straps();
        conclude();
    end
endmodule
